// ==== common/clksw_defs.vh ====
// Constants for the system clock switcher: source codes, keys, fields and counts.
`ifndef CLKSW_DEFS_VH
`define CLKSW_DEFS_VH

// Three-bit source selection codes used by the new and current source fields.
`define SRC_FAST_RC      3'h0
`define SRC_FAST_RC_PLL  3'h1
`define SRC_PRIMARY      3'h2
`define SRC_PRIMARY_PLL  3'h3
`define SRC_LP_XTAL      3'h4
`define SRC_LOW_POWER_RC 3'h5

// Oscillator enable bit positions.
`define OSC_BIT_FAST_RC  0
`define OSC_BIT_PRIMARY  1
`define OSC_BIT_LP_XTAL  2
`define OSC_BIT_LOW_POWER_RC_OSC     3

// Primary oscillator submode codes.
`define SUBMODE_EXTERNAL_CLOCK 2'h0
`define SUBMODE_CRYSTAL        2'h1
`define SUBMODE_HS_CRYSTAL     2'h2
`define SUBMODE_OFF            2'h3

// Unlock keys: two key writes in a row open one byte of the control register.
`define KEY_HIGH_FIRST  8'h78
`define KEY_HIGH_SECOND 8'h9A
`define KEY_LOW_FIRST   8'h46
`define KEY_LOW_SECOND  8'h57

// Low byte field positions.
`define LOW_SWITCH_REQ_BIT 0
`define LOW_CLOCK_FAIL_BIT 3

// Timing counts in cycles of the target clock (ticks) or system clock.
`define STARTUP_TIMER_TICKS 11'h400
`define SETTLE_TICKS        11'h00A
`define UNLOCK_WINDOW       4'h8

`endif

// ==== rtl/system_clock_switcher.v ====
// System clock switcher: unlock-protected control of four oscillator sources.
`include "clksw_defs.vh"

// Overview of operation
// [R1] Switching and fail-safe only when config bit zero.
// [R2] Disabled: current source follows reset configuration.
// [R3] Disabled: switch request ignored, reads zero.
// [R4] Software unlocks high byte, then low byte.
// [R5] Equal current and new source aborts request.
// [R6] Valid switch start clears lock, fail flags.
// [R7] Start oscillator, wait startup timer or lock.
// [R8] Count ten new-clock cycles before switching over.
// [R9] Completion clears request, copies new to current.
// [R10] Old source off, except low-power RC if needed.
// [R11] Processor runs on; busy shown during sequence.
// [R12] No direct switch between the two PLL modes; the code does not block such a switch.
// [R13] Primary submode fixed by configuration field.
// [R14] Any of the four sources selectable when enabled.
// [R15] Each byte write needs its key sequence first.
module system_clock_switcher #(
	parameter [10:0] OST_TICKS = `STARTUP_TIMER_TICKS, // Start-up timer length in ticks.
	parameter [10:0] SETTLE = `SETTLE_TICKS // New-clock cycles before switch-over.
) (
	input wire CLK, // System clock, 100 MHz.
	input wire RST_N, // Asynchronous reset, active low.
	input wire SWITCH_FAIL_SAFE_CFG, // Zero enables switching and fail-safe monitor.
	input wire [2:0] RESET_SOURCE_CFG, // Source chosen at reset.
	input wire [1:0] PRIMARY_SUBMODE_CFG, // Primary oscillator submode.
	input wire WATCHDOG_EN, // Watchdog enabled, keeps low-power RC alive.
	input wire KEY_WR, // Key write strobe.
	input wire [7:0] KEY_DATA, // Key value.
	input wire WR_HIGH, // High byte write strobe.
	input wire WR_LOW, // Low byte write strobe.
	input wire [7:0] WR_DATA, // Byte written.
	input wire NEW_CLK_TICK, // One pulse per cycle of the target clock.
	input wire PLL_LOCKED, // PLL lock detector.
	input wire CLOCK_FAIL_EVENT, // Fail-safe monitor saw the clock fail.
	output reg [2:0] NEW_SOURCE_SEL, // New source field.
	output reg [2:0] CURRENT_SOURCE_SEL, // Current source field.
	output reg SWITCH_REQUEST, // Switch request bit.
	output reg PLL_LOCK_FLAG, // PLL lock status flag.
	output reg CLOCK_FAIL_FLAG, // Clock fail status flag.
	output reg [3:0] OSC_ENABLE, // Oscillator enables.
	output reg PLL_ENABLE, // PLL enable.
	output reg [1:0] PRIMARY_SUBMODE, // Submode applied to the primary oscillator.
	output reg SWITCH_BUSY // Switch sequence in progress.
);

	localparam [2:0] ST_IDLE = 3'h1; // No switch in progress.
	localparam [2:0] ST_WAIT = 3'h2; // Waiting for the target source to be ready.
	localparam [2:0] ST_SETTLE = 3'h4; // Counting new-clock cycles.

	// Oscillator enable bits that a source needs.
	function [3:0] src_osc;
		input [2:0] src;
		begin
			case (src)
				`SRC_FAST_RC, `SRC_FAST_RC_PLL: src_osc = 4'h1 << `OSC_BIT_FAST_RC;
				`SRC_PRIMARY, `SRC_PRIMARY_PLL: src_osc = 4'h1 << `OSC_BIT_PRIMARY;
				`SRC_LP_XTAL: src_osc = 4'h1 << `OSC_BIT_LP_XTAL;
				`SRC_LOW_POWER_RC: src_osc = 4'h1 << `OSC_BIT_LOW_POWER_RC_OSC;
				default: src_osc = 4'h1 << `OSC_BIT_FAST_RC;
			endcase
		end
	endfunction

	// True when a source runs through the PLL.
	function uses_pll;
		input [2:0] src;
		begin
			uses_pll = (src == `SRC_FAST_RC_PLL) || (src == `SRC_PRIMARY_PLL);
		end
	endfunction

	reg [2:0] state_q, state_d; // Sequencer state.
	reg [10:0] tick_q, tick_d; // Count of target clock ticks.
	reg need_ost_q, need_ost_d; // Target is a crystal that was just started.
	reg init_q; // Set until the reset configuration has been captured.
	reg key_hi_q, key_lo_q; // First key of a sequence seen.
	reg unl_hi_q, unl_lo_q; // Byte unlocked for the next write.
	reg [3:0] win_q; // Cycles left in the unlock window.
	reg [2:0] new_d, cur_d; // Next values of the source fields.
	reg req_d, lock_d, fail_d, pll_d, busy_d; // Next values of status and controls.
	reg [3:0] osc_d; // Next oscillator enables.
	wire sw_en = ~SWITCH_FAIL_SAFE_CFG; // [R1]
	wire hi_ok = WR_HIGH & unl_hi_q; // [R15]
	wire lo_ok = WR_LOW & unl_lo_q; // [R15]
	wire is_xtal = (NEW_SOURCE_SEL == `SRC_LP_XTAL) ||
		(((NEW_SOURCE_SEL == `SRC_PRIMARY) || (NEW_SOURCE_SEL == `SRC_PRIMARY_PLL)) &&
		((PRIMARY_SUBMODE == `SUBMODE_CRYSTAL) || (PRIMARY_SUBMODE == `SUBMODE_HS_CRYSTAL)));
	wire [3:0] keep_low_power_rc_osc = (WATCHDOG_EN | sw_en) ? (4'h1 << `OSC_BIT_LOW_POWER_RC_OSC) : 4'h0; // [R10]

	// Key sequence tracking and the unlock window for each byte.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			key_hi_q <= 1'b0;
			key_lo_q <= 1'b0;
			unl_hi_q <= 1'b0;
			unl_lo_q <= 1'b0;
			win_q <= 4'h0;
		end else begin
			if (KEY_WR) begin
				// A second key only counts right after its first key.
				key_hi_q <= (KEY_DATA == `KEY_HIGH_FIRST); // [R15]
				key_lo_q <= (KEY_DATA == `KEY_LOW_FIRST); // [R15]
				if (key_hi_q && KEY_DATA == `KEY_HIGH_SECOND) begin
					unl_hi_q <= 1'b1; // [R15]
					win_q <= `UNLOCK_WINDOW;
				end else if (key_lo_q && KEY_DATA == `KEY_LOW_SECOND) begin
					unl_lo_q <= 1'b1; // [R15]
					win_q <= `UNLOCK_WINDOW;
				end
			end else if (WR_HIGH || WR_LOW || win_q == 4'h1) begin
				// A write attempt in a cycle without a key write, or the window running out, relocks both bytes.
				unl_hi_q <= 1'b0;
				unl_lo_q <= 1'b0;
				win_q <= 4'h0;
			end else if (win_q != 4'h0) begin
				win_q <= win_q - 4'h1;
			end
		end
	end

	// Sequencer and register next values.
	always @* begin
		state_d = state_q;
		tick_d = tick_q;
		need_ost_d = need_ost_q;
		new_d = hi_ok ? WR_DATA[2:0] : NEW_SOURCE_SEL; // [R4] [R14]
		cur_d = CURRENT_SOURCE_SEL;
		req_d = SWITCH_REQUEST;
		osc_d = OSC_ENABLE;
		pll_d = PLL_ENABLE;
		busy_d = 1'b0;
		// Hardware sets win over a software clear.
		lock_d = PLL_LOCKED | PLL_LOCK_FLAG;
		fail_d = (CLOCK_FAIL_EVENT & sw_en) | // [R1]
			(CLOCK_FAIL_FLAG & ~(lo_ok & ~WR_DATA[`LOW_CLOCK_FAIL_BIT]));
		if (lo_ok && WR_DATA[`LOW_SWITCH_REQ_BIT] && sw_en) begin
			req_d = 1'b1; // [R4]
		end
		case (state_q)
			ST_IDLE: begin
				if (SWITCH_REQUEST) begin
					if (NEW_SOURCE_SEL == CURRENT_SOURCE_SEL) begin
						req_d = 1'b0; // [R5]
					end else begin
						lock_d = 1'b0; // [R6]
						fail_d = CLOCK_FAIL_EVENT & sw_en; // [R6]
						need_ost_d = is_xtal & ~|(OSC_ENABLE & src_osc(NEW_SOURCE_SEL)); // [R7]
						osc_d = OSC_ENABLE | src_osc(NEW_SOURCE_SEL); // [R7]
						pll_d = PLL_ENABLE | uses_pll(NEW_SOURCE_SEL); // [R7]
						tick_d = 11'h000;
						busy_d = 1'b1; // [R11]
						state_d = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				busy_d = 1'b1; // [R11]
				if (need_ost_q && NEW_CLK_TICK) begin
					tick_d = tick_q + 11'h001;
				end
				// Ready once the start-up timer ran out and the PLL, if used, has locked.
				if ((!need_ost_q || tick_q >= OST_TICKS) &&
					(!uses_pll(NEW_SOURCE_SEL) || PLL_LOCKED)) begin // [R7]
					tick_d = 11'h000;
					state_d = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				busy_d = 1'b1; // [R11]
				if (NEW_CLK_TICK) begin
					tick_d = tick_q + 11'h001;
				end
				if (NEW_CLK_TICK && tick_q == SETTLE - 11'h001) begin // [R8]
					cur_d = NEW_SOURCE_SEL; // [R9]
					req_d = 1'b0; // [R9]
					osc_d = src_osc(NEW_SOURCE_SEL) | keep_low_power_rc_osc; // [R10]
					pll_d = uses_pll(NEW_SOURCE_SEL); // [R10]
					busy_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!sw_en) begin
			// Disabled: no sequence runs and the current source is the reset choice.
			req_d = 1'b0; // [R3]
			cur_d = RESET_SOURCE_CFG; // [R2]
			osc_d = src_osc(RESET_SOURCE_CFG) | keep_low_power_rc_osc; // [R2]
			pll_d = uses_pll(RESET_SOURCE_CFG); // [R2]
			busy_d = 1'b0;
			state_d = ST_IDLE;
		end
	end

	// State and output registers; the reset choice is captured after release.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			tick_q <= 11'h000;
			need_ost_q <= 1'b0;
			init_q <= 1'b1;
			NEW_SOURCE_SEL <= `SRC_FAST_RC;
			CURRENT_SOURCE_SEL <= `SRC_FAST_RC;
			SWITCH_REQUEST <= 1'b0;
			PLL_LOCK_FLAG <= 1'b0;
			CLOCK_FAIL_FLAG <= 1'b0;
			OSC_ENABLE <= 4'h1 << `OSC_BIT_FAST_RC;
			PLL_ENABLE <= 1'b0;
			PRIMARY_SUBMODE <= `SUBMODE_OFF;
			SWITCH_BUSY <= 1'b0;
		end else if (init_q) begin
			// First edge after reset: adopt the configured source and submode.
			init_q <= 1'b0;
			NEW_SOURCE_SEL <= RESET_SOURCE_CFG;
			CURRENT_SOURCE_SEL <= RESET_SOURCE_CFG; // [R2]
			OSC_ENABLE <= src_osc(RESET_SOURCE_CFG) | keep_low_power_rc_osc;
			PLL_ENABLE <= uses_pll(RESET_SOURCE_CFG);
			PRIMARY_SUBMODE <= PRIMARY_SUBMODE_CFG; // [R13]
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			need_ost_q <= need_ost_d;
			NEW_SOURCE_SEL <= new_d;
			CURRENT_SOURCE_SEL <= cur_d;
			SWITCH_REQUEST <= req_d;
			PLL_LOCK_FLAG <= lock_d;
			CLOCK_FAIL_FLAG <= fail_d;
			OSC_ENABLE <= osc_d;
			PLL_ENABLE <= pll_d;
			PRIMARY_SUBMODE <= PRIMARY_SUBMODE_CFG; // [R13]
			SWITCH_BUSY <= busy_d;
		end
	end

endmodule

// ==== verif/clksw_assertions.sv ====
// Concurrent checks on the clock switcher's ports.
module clksw_assertions #(
	parameter [10:0] SETTLE = 11'h00A // New-clock cycles before switch-over.
) (
	input wire CLK, // System clock.
	input wire RST_N, // Reset, active low.
	input wire SWITCH_FAIL_SAFE_CFG, // One disables switching.
	input wire [2:0] RESET_SOURCE_CFG, // Source chosen at reset.
	input wire NEW_CLK_TICK, // Target clock tick.
	input wire [2:0] NEW_SOURCE_SEL, // New source field.
	input wire [2:0] CURRENT_SOURCE_SEL, // Current source field.
	input wire SWITCH_REQUEST, // Switch request bit.
	input wire PLL_LOCK_FLAG, // Lock flag.
	input wire CLOCK_FAIL_FLAG, // Fail flag.
	input wire [1:0] PRIMARY_SUBMODE, // Applied submode.
	input wire SWITCH_BUSY // Sequence in progress.
);
	timeunit 1ns;
	timeprecision 1ps;
	int tick_cnt_q; // Target ticks seen while busy.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// Counts target ticks during a switch so the settle wait can be judged at its end.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			tick_cnt_q <= 0;
		else if (!SWITCH_BUSY)
			tick_cnt_q <= 0;
		else if (NEW_CLK_TICK)
			tick_cnt_q <= tick_cnt_q + 1;
	end
	// A request seen in idle while switching is enabled.
	sequence s_start;
		!SWITCH_FAIL_SAFE_CFG && SWITCH_REQUEST && !SWITCH_BUSY;
	endsequence
	// A switch that ran to its end rather than being cut off by disabling.
	sequence s_done;
		!SWITCH_FAIL_SAFE_CFG ##1 $fell(SWITCH_BUSY);
	endsequence
	a_req_held_zero: assert property ($past(SWITCH_FAIL_SAFE_CFG) && SWITCH_FAIL_SAFE_CFG
		|-> !SWITCH_REQUEST) else $error("request bit set while switching disabled");
	a_cur_from_cfg: assert property ($past(RST_N) && $past(SWITCH_FAIL_SAFE_CFG)
		&& SWITCH_FAIL_SAFE_CFG && $stable(RESET_SOURCE_CFG)
		|-> CURRENT_SOURCE_SEL == RESET_SOURCE_CFG) else $error("current source not from cfg");
	a_redundant_drop: assert property (s_start ##0 (NEW_SOURCE_SEL == CURRENT_SOURCE_SEL)
		|=> !SWITCH_REQUEST && !SWITCH_BUSY) else $error("redundant request not aborted");
	a_valid_goes_busy: assert property (s_start ##0 (NEW_SOURCE_SEL != CURRENT_SOURCE_SEL)
		|=> SWITCH_BUSY) else $error("valid request did not start a switch");
	a_start_clears: assert property ($rose(SWITCH_BUSY)
		|-> !PLL_LOCK_FLAG && !CLOCK_FAIL_FLAG) else $error("flags not cleared at start");
	a_settle_ticks: assert property (s_done |-> tick_cnt_q >= SETTLE)
		else $error("switch ended before the settle count");
	a_done_copies: assert property (s_done
		|-> CURRENT_SOURCE_SEL == NEW_SOURCE_SEL && !SWITCH_REQUEST)
		else $error("completion did not copy source or clear request");
	a_submode_fixed: assert property ($past(RST_N) && $past(RST_N, 2)
		|-> $stable(PRIMARY_SUBMODE)) else $error("primary submode changed at run time");
endmodule
bind system_clock_switcher clksw_assertions #(.SETTLE(SETTLE)) u_clksw_assertions (
	.CLK(CLK), .RST_N(RST_N), .SWITCH_FAIL_SAFE_CFG(SWITCH_FAIL_SAFE_CFG),
	.RESET_SOURCE_CFG(RESET_SOURCE_CFG), .NEW_CLK_TICK(NEW_CLK_TICK),
	.NEW_SOURCE_SEL(NEW_SOURCE_SEL), .CURRENT_SOURCE_SEL(CURRENT_SOURCE_SEL),
	.SWITCH_REQUEST(SWITCH_REQUEST), .PLL_LOCK_FLAG(PLL_LOCK_FLAG),
	.CLOCK_FAIL_FLAG(CLOCK_FAIL_FLAG), .PRIMARY_SUBMODE(PRIMARY_SUBMODE),
	.SWITCH_BUSY(SWITCH_BUSY));

// ==== verif/tb_top.sv ====
// Self-checking testbench for the system clock switcher.
`include "clksw_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST_N, SWITCH_FAIL_SAFE_CFG, WATCHDOG_EN, KEY_WR, WR_HIGH, WR_LOW;
	logic NEW_CLK_TICK, PLL_LOCKED, CLOCK_FAIL_EVENT, SWITCH_REQUEST, PLL_LOCK_FLAG;
	logic CLOCK_FAIL_FLAG, PLL_ENABLE, SWITCH_BUSY;
	logic [7:0] KEY_DATA, WR_DATA;
	logic [2:0] RESET_SOURCE_CFG, NEW_SOURCE_SEL, CURRENT_SOURCE_SEL;
	logic [1:0] PRIMARY_SUBMODE_CFG, PRIMARY_SUBMODE;
	logic [3:0] OSC_ENABLE;
	int num_errors = 0; // Mismatches seen.
	int n_checks = 0; // Comparisons made.
	// A short start-up timer keeps the crystal wait brief.
	system_clock_switcher #(.OST_TICKS(11'h004)) u_system_clock_switcher (
		.CLK(CLK), .RST_N(RST_N), .SWITCH_FAIL_SAFE_CFG(SWITCH_FAIL_SAFE_CFG),
		.RESET_SOURCE_CFG(RESET_SOURCE_CFG), .PRIMARY_SUBMODE_CFG(PRIMARY_SUBMODE_CFG),
		.WATCHDOG_EN(WATCHDOG_EN), .KEY_WR(KEY_WR), .KEY_DATA(KEY_DATA), .WR_HIGH(WR_HIGH),
		.WR_LOW(WR_LOW), .WR_DATA(WR_DATA), .NEW_CLK_TICK(NEW_CLK_TICK),
		.PLL_LOCKED(PLL_LOCKED), .CLOCK_FAIL_EVENT(CLOCK_FAIL_EVENT),
		.NEW_SOURCE_SEL(NEW_SOURCE_SEL), .CURRENT_SOURCE_SEL(CURRENT_SOURCE_SEL),
		.SWITCH_REQUEST(SWITCH_REQUEST), .PLL_LOCK_FLAG(PLL_LOCK_FLAG),
		.CLOCK_FAIL_FLAG(CLOCK_FAIL_FLAG), .OSC_ENABLE(OSC_ENABLE), .PLL_ENABLE(PLL_ENABLE),
		.PRIMARY_SUBMODE(PRIMARY_SUBMODE), .SWITCH_BUSY(SWITCH_BUSY));
	// Free-running 100 MHz clock.
	always #5 CLK = ~CLK;
	// Compares one value and counts the outcome.
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Sends the two consecutive keys that open one byte.
	task unlock(input logic hi);
		@(negedge CLK);
		KEY_WR = 1;
		KEY_DATA = hi ? `KEY_HIGH_FIRST : `KEY_LOW_FIRST;
		@(negedge CLK);
		KEY_DATA = hi ? `KEY_HIGH_SECOND : `KEY_LOW_SECOND;
		@(negedge CLK);
		KEY_WR = 0;
	endtask
	// One byte write strobe, then a cycle for the field to update.
	task write_byte(input logic hi, input logic [7:0] d);
		WR_HIGH = hi;
		WR_LOW = !hi;
		WR_DATA = d;
		@(negedge CLK);
		WR_HIGH = 0;
		WR_LOW = 0;
		@(negedge CLK);
	endtask
	// Full software sequence: new source in the high byte, then the request bit.
	task request(input logic [2:0] src);
		unlock(1);
		write_byte(1, {5'h00, src});
		unlock(0);
		// Fail bit written as one, so software never clears the fail flag here.
		write_byte(0, 8'h09);
	endtask
	// Pulses the target clock tick n times.
	task ticks(input int n);
		repeat (n) begin
			@(negedge CLK);
			NEW_CLK_TICK = 1;
			@(negedge CLK);
			NEW_CLK_TICK = 0;
		end
	endtask
	// Waits a bounded time for the busy level, then checks it.
	task wait_busy(input logic lvl);
		for (int i = 0; i < 10 && SWITCH_BUSY !== lvl; i++)
			@(negedge CLK);
		chk(SWITCH_BUSY, lvl);
	endtask
	// Prints the verdict and ends the run.
	task print_verdict;
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Cuts a hang short well past the expected run length.
	initial begin
		#200000;
		num_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict;
	end
	// Main sequence.
	initial begin
		{CLK, RST_N, KEY_WR, WR_HIGH, WR_LOW, NEW_CLK_TICK, PLL_LOCKED, CLOCK_FAIL_EVENT} = 0;
		{SWITCH_FAIL_SAFE_CFG, WATCHDOG_EN} = 2'h3;
		{KEY_DATA, WR_DATA, RESET_SOURCE_CFG, PRIMARY_SUBMODE_CFG} = {16'h0000, 3'h0, 2'h1};
		repeat (2) @(negedge CLK);
		RST_N = 1;
		repeat (2) @(negedge CLK);
		chk(PRIMARY_SUBMODE, 4'h1);
		write_byte(1, 8'h05);
		chk(NEW_SOURCE_SEL, 4'h0);
		request(`SRC_LP_XTAL);
		chk(NEW_SOURCE_SEL, 4'h4);
		chk(SWITCH_REQUEST, 4'h0);
		chk(CURRENT_SOURCE_SEL, 4'h0);
		SWITCH_FAIL_SAFE_CFG = 0;
		request(`SRC_LP_XTAL);
		wait_busy(1);
		ticks(13);
		chk(SWITCH_BUSY, 4'h1);
		ticks(1);
		wait_busy(0);
		chk(CURRENT_SOURCE_SEL, 4'h4);
		chk(OSC_ENABLE, 4'hC);
		request(`SRC_LP_XTAL);
		repeat (3) @(negedge CLK);
		chk({SWITCH_REQUEST, CURRENT_SOURCE_SEL}, 4'h4);
		// A one-cycle lock pulse leaves the lock flag set, so the next start must clear it.
		CLOCK_FAIL_EVENT = 1;
		PLL_LOCKED = 1;
		@(negedge CLK);
		CLOCK_FAIL_EVENT = 0;
		PLL_LOCKED = 0;
		@(negedge CLK);
		chk({PLL_LOCK_FLAG, CLOCK_FAIL_FLAG}, 4'h3);
		// Target is the fast RC with PLL, reached from a non-PLL source.
		request(`SRC_FAST_RC_PLL);
		wait_busy(1);
		chk({PLL_LOCK_FLAG, CLOCK_FAIL_FLAG}, 4'h0);
		ticks(12);
		chk(SWITCH_BUSY, 4'h1);
		PLL_LOCKED = 1;
		ticks(10);
		wait_busy(0);
		chk({PLL_LOCK_FLAG, CURRENT_SOURCE_SEL}, 4'h9);
		chk({PLL_ENABLE, 3'h0}, 4'h8);
		chk(OSC_ENABLE, 4'h9);
		// Disabling with a new reset choice must hand the current field to that choice.
		SWITCH_FAIL_SAFE_CFG = 1;
		RESET_SOURCE_CFG = `SRC_LOW_POWER_RC;
		repeat (3) @(negedge CLK);
		chk(CURRENT_SOURCE_SEL, 4'h5);
		chk(OSC_ENABLE, 4'h8);
		// With the monitor disabled a fail event must not set the flag.
		CLOCK_FAIL_EVENT = 1;
		@(negedge CLK);
		CLOCK_FAIL_EVENT = 0;
		@(negedge CLK);
		chk(CLOCK_FAIL_FLAG, 4'h0);
		print_verdict;
	end
endmodule
